/* common/ccai_pkg.sv */
// constants of the contactless card command interpreter
// assumes one 100 MHz clock and a synchronous active-high reset
package ccai_pkg;

    localparam logic [7:0]  CLA_DIRECT   = 8'hff;
    localparam logic [7:0]  INS_GET_NAME = 8'h3a;
    localparam logic [7:0]  INS_SLOT     = 8'h3c;
    localparam logic [7:0]  INS_WRAP     = 8'h3e;
    localparam logic [7:0]  INS_READ     = 8'h40;
    localparam logic [7:0]  INS_UPDATE   = 8'h42;
    localparam logic [7:0]  INS_VALUE    = 8'h44;

    localparam logic [15:0] SLOT_DESELECT = 16'h2000;
    localparam logic [15:0] SLOT_RST_NOBP = 16'h1003;

    localparam logic [7:0]  VAL_P1_INC     = 8'h00;
    localparam logic [7:0]  VAL_P1_DEC     = 8'h01;
    localparam logic [7:0]  VAL_P1_RESTORE = 8'h02;
    localparam logic [7:0]  VALUE_LEN      = 8'h04;

    localparam logic [7:0]  MAX_BLK_1K   = 8'h3f;
    localparam logic [7:0]  MAX_BLK_4K   = 8'hff;
    localparam logic [7:0]  BIG_SEC_BASE = 8'h80;
    localparam logic [3:0]  DBLK_SMALL   = 4'h3;
    localparam logic [3:0]  DBLK_BIG     = 4'hf;
    localparam int          HIDE_BIT     = 6;

    localparam logic [15:0] NAME_NONE  = 16'h0000;
    localparam logic [15:0] NAME_MEM1K = 16'h0001;
    localparam logic [15:0] NAME_MEM4K = 16'h0002;

    localparam logic [15:0] SW_OK      = 16'h9000;
    localparam logic [7:0]  SW_NATIVE  = 8'h91;
    localparam logic [15:0] SW_LEN     = 16'h6700;
    localparam logic [15:0] SW_COND    = 16'h6985;
    localparam logic [15:0] SW_P1P2    = 16'h6b00;
    localparam logic [15:0] SW_INS     = 16'h6d00;
    localparam logic [15:0] SW_CLA     = 16'h6e00;
    localparam logic [15:0] SW_CARD    = 16'h6f00;

    typedef enum logic [2:0] {
        FAM_NONE     = 3'b000,
        FAM_MEM1K    = 3'b001,
        FAM_MEM4K    = 3'b010,
        FAM_GEN_A    = 3'b011,
        FAM_GEN_B    = 3'b100,
        FAM_VICINITY = 3'b101,
        FAM_VIRTUAL  = 3'b110,
        FAM_SECURE1  = 3'b111
    } ccai_fam_t;

    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_READ     = 4'h1,
        OP_WRITE    = 4'h2,
        OP_INC      = 4'h3,
        OP_DEC      = 4'h4,
        OP_RESTORE  = 4'h5,
        OP_TRANSFER = 4'h6,
        OP_NATIVE   = 4'h7,
        OP_DESELECT = 4'h8,
        OP_FIELD_RST = 4'h9
    } ccai_op_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_COLLECT = 3'b001,
        ST_EXEC    = 3'b010,
        ST_WDATA   = 3'b011,
        ST_WAIT    = 3'b100,
        ST_REPLY   = 3'b101,
        ST_SW      = 3'b110
    } ccai_state_t;

endpackage

/* rtl/ccai_buf_mem.sv */
// byte buffer for command data bound for the card
// assumes one clock; read data appear one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module ccai_buf_mem #(
    parameter int W     = 8,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // clock
    input  wire logic          clock,
    // write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // read side
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [W-1:0]  rd_data_q
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule // ccai_buf_mem
`default_nettype wire

/* rtl/ccai_top.sv */
// command interpreter turning host command packets into card operations
// assumes card detection and the card link are same-clock logic
`timescale 1ns/1ps
`default_nettype none
module ccai_top
    import ccai_pkg::*;
#(
    // name codes below are arbitrary values
    parameter logic [15:0] NAME_GEN_A    = 16'he5a1,
    parameter logic [15:0] NAME_GEN_B    = 16'he5b1,
    parameter logic [15:0] NAME_VICINITY = 16'he5c1,
    parameter logic [15:0] NAME_VIRTUAL  = 16'he5f1
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // option register
    input  wire logic [7:0] opt_reg,
    input  wire logic       opt_bp_off,
    // card detection
    input  wire logic       card_arrive,
    input  wire logic [2:0] card_family,
    input  wire logic       card_bp_cap,
    // command header
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_cla,
    input  wire logic [7:0] cmd_ins,
    input  wire logic [7:0] cmd_p1,
    input  wire logic [7:0] cmd_p2,
    input  wire logic [7:0] cmd_len,
    output var  logic       cmd_ready_q,
    // command data
    input  wire logic       cmd_data_valid,
    input  wire logic [7:0] cmd_data,
    output var  logic       cmd_data_ready_q,
    // response
    output var  logic       rsp_valid_q,
    output var  logic [7:0] rsp_data_q,
    output var  logic       rsp_done_q,
    output var  logic [15:0] rsp_sw_q,
    // card state
    output var  logic [15:0] card_name_code_q,
    output var  logic       card_high_level_q,
    // card operations
    output var  logic       card_req_q,
    output var  logic [3:0] card_op_q,
    output var  logic [7:0] card_blk_q,
    output var  logic [7:0] card_len_q,
    output var  logic       card_wvalid_q,
    output var  logic [7:0] card_wdata_q,
    input  wire logic       card_rvalid,
    input  wire logic [7:0] card_rdata,
    input  wire logic       card_done,
    input  wire logic       card_err,
    input  wire logic [7:0] card_stat
);
    ccai_state_t state_q;
    ccai_fam_t   fam_q;
    logic        bp_tmp_off_q;
    logic [7:0]  cla_q, ins_q, p1_q, p2_q, len_q;
    logic [7:0]  cnt_q;
    logic        wpend_q;
    logic        xfer_q;
    logic [7:0]  mem_rdata;
    logic [15:0] chk_sw;
    logic [7:0]  lastb;
    logic        aligned;
    logic [3:0]  nblk;
    logic [8:0]  endb;
    logic [7:0]  maxb;
    logic        mem_card;
    logic        slot_go;
    logic        buf_wr;

    // hide bit blanks proprietary codes
    function automatic logic [15:0] name_of(input logic [2:0] f,
                                            input logic hide);
        logic [15:0] prop;
        prop = NAME_NONE;
        case (f)
            FAM_MEM1K:    return NAME_MEM1K;
            FAM_MEM4K:    return NAME_MEM4K;
            FAM_GEN_A:    prop = NAME_GEN_A;
            FAM_GEN_B:    prop = NAME_GEN_B;
            FAM_VICINITY: prop = NAME_VICINITY;
            FAM_VIRTUAL:  prop = NAME_VIRTUAL;
            default:      prop = NAME_NONE;
        endcase
        return hide ? NAME_NONE : prop;
    endfunction

    // trailer: last block of b's sector
    function automatic logic [7:0] sec_last(input logic [7:0] b);
        return (b < BIG_SEC_BASE) ? {b[7:2], 2'b11}
                                  : {b[7:4], 4'hf};
    endfunction

    assign mem_card = (fam_q == FAM_MEM1K) || (fam_q == FAM_MEM4K);
    assign maxb     = (fam_q == FAM_MEM4K) ? MAX_BLK_4K : MAX_BLK_1K;
    assign lastb    = sec_last(p2_q);
    assign aligned  = (p2_q < BIG_SEC_BASE) ? (p2_q[1:0] == 2'b00)
                                            : (p2_q[3:0] == 4'h0);
    assign slot_go  = (state_q == ST_EXEC) && (chk_sw == SW_OK)
                      && (ins_q == INS_SLOT);
    assign buf_wr   = (state_q == ST_COLLECT) && cmd_data_valid
                      && cmd_data_ready_q;

    // block count and pre-access checks
    always_comb begin
        if (len_q == 8'h00) begin
            if (aligned) begin
                nblk = (p2_q < BIG_SEC_BASE) ? DBLK_SMALL : DBLK_BIG;
            end else begin
                nblk = 4'h1;
            end
        end else begin
            nblk = len_q[7:4];
        end
        endb = {1'b0, p2_q} + {5'h00, nblk} - 9'h001;
        chk_sw = SW_OK;
        if (cla_q != CLA_DIRECT) begin
            chk_sw = SW_CLA;
        end else begin
            case (ins_q)
                INS_GET_NAME: begin
                    if (p1_q != 8'h00) chk_sw = SW_P1P2;
                end
                INS_SLOT: begin
                    if ({p1_q, p2_q} != SLOT_DESELECT &&
                        {p1_q, p2_q} != SLOT_RST_NOBP) chk_sw = SW_P1P2;
                end
                INS_WRAP: begin
                    if (fam_q != FAM_SECURE1) chk_sw = SW_COND;
                    else if (p1_q != 8'h00) chk_sw = SW_P1P2;
                end
                INS_READ, INS_UPDATE: begin
                    if (!mem_card || card_high_level_q) chk_sw = SW_COND;
                    else if (p1_q != 8'h00 || p2_q > maxb ||
                             (ins_q == INS_UPDATE && p2_q == 8'h00))
                        chk_sw = SW_P1P2;
                    else if (len_q[3:0] != 4'h0 ||
                             (ins_q == INS_UPDATE && len_q == 8'h00))
                        chk_sw = SW_LEN;
                    else if (endb > {1'b0, lastb})
                        chk_sw = SW_P1P2;
                end
                INS_VALUE: begin
                    if (!mem_card || card_high_level_q) chk_sw = SW_COND;
                    else if (p1_q > VAL_P1_RESTORE || p2_q > maxb ||
                             p2_q == lastb) chk_sw = SW_P1P2;
                    else if (len_q != VALUE_LEN) chk_sw = SW_LEN;
                end
                default: chk_sw = SW_INS;
            endcase
        end
    end

    // card identity and presentation level
    always_ff @(posedge clock) begin
        if (rst) begin
            fam_q             <= FAM_NONE;
            card_name_code_q  <= NAME_NONE;
            card_high_level_q <= 1'b0;
            bp_tmp_off_q      <= 1'b0;
        end else if (card_arrive) begin
            fam_q            <= ccai_fam_t'(card_family);
            card_name_code_q <= name_of(card_family, opt_reg[HIDE_BIT]);
            card_high_level_q <= card_bp_cap && !opt_bp_off
                                 && !bp_tmp_off_q;
            bp_tmp_off_q     <= 1'b0;
        end else if (slot_go) begin
            card_high_level_q <= 1'b0;
            if ({p1_q, p2_q} == SLOT_RST_NOBP) begin
                bp_tmp_off_q <= 1'b1;
            end
        end
    end

    // command sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q          <= ST_IDLE;
            cmd_ready_q      <= 1'b0;
            cmd_data_ready_q <= 1'b0;
            {cla_q, ins_q, p1_q, p2_q, len_q} <= 40'h00_0000_0000;
            cnt_q            <= 8'h00;
            wpend_q          <= 1'b0;
            xfer_q           <= 1'b0;
            rsp_valid_q      <= 1'b0;
            rsp_data_q       <= 8'h00;
            rsp_done_q       <= 1'b0;
            rsp_sw_q         <= SW_OK;
            card_req_q       <= 1'b0;
            card_op_q        <= OP_NONE;
            card_blk_q       <= 8'h00;
            card_len_q       <= 8'h00;
            card_wvalid_q    <= 1'b0;
            card_wdata_q     <= 8'h00;
        end else begin
            rsp_valid_q   <= 1'b0;
            rsp_done_q    <= 1'b0;
            card_req_q    <= 1'b0;
            card_wvalid_q <= wpend_q;
            card_wdata_q  <= mem_rdata;
            wpend_q       <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    cmd_ready_q <= 1'b1;
                    if (cmd_valid && cmd_ready_q) begin
                        cmd_ready_q <= 1'b0;
                        {cla_q, ins_q, p1_q, p2_q, len_q} <=
                            {cmd_cla, cmd_ins, cmd_p1, cmd_p2, cmd_len};
                        cnt_q  <= 8'h00;
                        xfer_q <= 1'b0;
                        if (cmd_len != 8'h00 && (cmd_ins == INS_UPDATE ||
                            cmd_ins == INS_VALUE || cmd_ins == INS_WRAP)) begin
                            state_q          <= ST_COLLECT;
                            cmd_data_ready_q <= 1'b1;
                        end else begin
                            state_q <= ST_EXEC;
                        end
                    end
                end
                ST_COLLECT: begin
                    if (buf_wr) begin
                        cnt_q <= cnt_q + 8'h01;
                        if (cnt_q == len_q - 8'h01) begin
                            cmd_data_ready_q <= 1'b0;
                            state_q          <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    cnt_q <= 8'h00;
                    if (chk_sw != SW_OK) begin
                        rsp_sw_q <= chk_sw;
                        state_q  <= ST_SW;
                    end else begin
                        card_blk_q <= p2_q;
                        card_len_q <= len_q;
                        card_req_q <= (ins_q != INS_GET_NAME);
                        state_q    <= ST_WAIT;
                        case (ins_q)
                            INS_GET_NAME: state_q <= ST_REPLY;
                            INS_SLOT: begin
                                card_op_q  <= ({p1_q, p2_q} == SLOT_DESELECT)
                                              ? OP_DESELECT : OP_FIELD_RST;
                            end
                            INS_READ: begin
                                card_op_q  <= OP_READ;
                                card_len_q <= {nblk, 4'h0};
                            end
                            INS_UPDATE: begin
                                card_op_q  <= OP_WRITE;
                                state_q    <= ST_WDATA;
                            end
                            INS_VALUE: begin
                                card_op_q  <= (p1_q == VAL_P1_INC) ? OP_INC :
                                              (p1_q == VAL_P1_DEC) ? OP_DEC :
                                              OP_RESTORE;
                                state_q    <= ST_WDATA;
                            end
                            default: begin
                                card_op_q  <= OP_NATIVE;
                                state_q    <= (len_q == 8'h00) ? ST_WAIT
                                                               : ST_WDATA;
                            end
                        endcase
                    end
                end
                ST_WDATA: begin
                    wpend_q <= 1'b1;
                    cnt_q   <= cnt_q + 8'h01;
                    if (cnt_q == len_q - 8'h01) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    rsp_valid_q <= card_rvalid;
                    rsp_data_q  <= card_rdata;
                    if (card_done) begin
                        if (card_err) begin
                            rsp_sw_q <= SW_CARD;
                            state_q  <= ST_SW;
                        end else if (ins_q == INS_VALUE && !xfer_q) begin
                            xfer_q     <= 1'b1;
                            card_req_q <= 1'b1;
                            card_op_q  <= OP_TRANSFER;
                            card_len_q <= 8'h00;
                        end else begin
                            rsp_sw_q <= (ins_q == INS_WRAP)
                                        ? {SW_NATIVE, card_stat}
                                        : SW_OK;
                            state_q  <= ST_SW;
                        end
                    end
                end
                ST_REPLY: begin
                    rsp_valid_q <= 1'b1;
                    rsp_data_q  <= cnt_q[0] ? card_name_code_q[7:0]
                                            : card_name_code_q[15:8];
                    cnt_q       <= cnt_q + 8'h01;
                    if (cnt_q[0]) begin
                        rsp_sw_q <= SW_OK;
                        state_q  <= ST_SW;
                    end
                end
                ST_SW: begin
                    rsp_done_q <= 1'b1;
                    state_q    <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ccai_buf_mem u_buf (
        .clock     (clock),
        .wr_en     (buf_wr),
        .wr_addr   (cnt_q),
        .wr_data   (cmd_data),
        .rd_addr   (cnt_q),
        .rd_data_q (mem_rdata)
    );
endmodule // ccai_top
`default_nettype wire

/* verification/ccai_props.sv */
// assertions on the command interpreter's ports
// assumes the host always sends the direct class byte
`timescale 1ns/1ps
`default_nettype none
module ccai_props
    import ccai_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // option and detection
    input  wire logic [7:0]  opt_reg,
    input  wire logic        opt_bp_off,
    input  wire logic        card_arrive,
    input  wire logic [2:0]  card_family,
    input  wire logic        card_bp_cap,
    // command and response
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_ins,
    input  wire logic [7:0]  cmd_p1,
    input  wire logic [7:0]  cmd_p2,
    input  wire logic [7:0]  cmd_len,
    input  wire logic        cmd_ready_q,
    input  wire logic        rsp_done_q,
    input  wire logic [15:0] rsp_sw_q,
    // card side
    input  wire logic [15:0] card_name_code_q,
    input  wire logic        card_high_level_q,
    input  wire logic        card_req_q,
    input  wire logic [3:0]  card_op_q,
    input  wire logic [7:0]  card_blk_q,
    input  wire logic [7:0]  card_len_q,
    input  wire logic        card_done,
    input  wire logic        card_err,
    input  wire logic [7:0]  card_stat
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic       nobp_q;
    logic [7:0] last_blk;
    assign last_blk = card_blk_q + (card_len_q >> 4) - 8'h01;
    // pending one-shot disable
    always_ff @(posedge clock) begin
        if (rst || card_arrive) begin
            nobp_q <= 1'b0;
        end else if (cmd_valid && cmd_ready_q && cmd_ins == INS_SLOT
                     && {cmd_p1, cmd_p2} == SLOT_RST_NOBP) begin
            nobp_q <= 1'b1;
        end
    end
    property p_name_std;
        card_arrive && card_family inside {FAM_MEM1K, FAM_MEM4K} |=>
        card_name_code_q == (($past(card_family) == FAM_MEM1K) ?
                             NAME_MEM1K : NAME_MEM4K);
    endproperty
    a_name_std: assert property (p_name_std)
        else $error("std name");
    property p_name_hide;
        card_arrive && opt_reg[HIDE_BIT] &&
        card_family inside {[FAM_GEN_A:FAM_VIRTUAL]} |=>
        card_name_code_q == NAME_NONE;
    endproperty
    a_name_hide: assert property (p_name_hide)
        else $error("hidden name");
    property p_bp_default;
        card_arrive && card_bp_cap && !opt_bp_off && !nobp_q |=>
        card_high_level_q;
    endproperty
    a_bp_default: assert property (p_bp_default)
        else $error("bp on");
    property p_bp_off;
        card_arrive && (opt_bp_off || nobp_q) |=> !card_high_level_q;
    endproperty
    a_bp_off: assert property (p_bp_off)
        else $error("bp off");
    property p_wrap_sw;
        card_done && !card_err && card_op_q == OP_NATIVE |=> ##1
        rsp_done_q && rsp_sw_q == {SW_NATIVE, $past(card_stat, 2)};
    endproperty
    a_wrap_sw: assert property (p_wrap_sw)
        else $error("wrap sw");
    property p_value_xfer;
        card_done && !card_err &&
        card_op_q inside {OP_INC, OP_DEC, OP_RESTORE} |=>
        card_req_q && card_op_q == OP_TRANSFER && card_len_q == 8'h00;
    endproperty
    a_value_xfer: assert property (p_value_xfer)
        else $error("no transfer");
    property p_len_blocks;
        card_req_q && card_op_q inside {OP_READ, OP_WRITE} |->
        card_len_q[3:0] == 4'h0 && card_len_q != 8'h00;
    endproperty
    a_len_blocks: assert property (p_len_blocks)
        else $error("card length");
    property p_in_sector;
        card_req_q && card_op_q inside {OP_READ, OP_WRITE} |->
        ((card_blk_q < BIG_SEC_BASE) ? last_blk[7:2] == card_blk_q[7:2]
                                     : last_blk[7:4] == card_blk_q[7:4]);
    endproperty
    a_in_sector: assert property (p_in_sector)
        else $error("sector crossed");
    property p_bad_len;
        cmd_valid && cmd_ready_q && cmd_ins == INS_READ &&
        cmd_len[3:0] != 4'h0 |=> !card_req_q ##1 !card_req_q ##1
        (rsp_done_q && !card_req_q && rsp_sw_q != SW_OK);
    endproperty
    a_bad_len: assert property (p_bad_len)
        else $error("bad length");
endmodule // ccai_props
bind ccai_top ccai_props u_props (.*);
`default_nettype wire

/* verification/ccai_card_model.sv */
// behavioural card behind the interpreter's card link
// assumes requests come one at a time, as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module ccai_card_model
    import ccai_pkg::*;
(
    // clock and stall control
    input  wire logic       clock,
    input  wire logic       slow,
    // card link
    input  wire logic       card_req_q,
    input  wire logic [3:0] card_op_q,
    input  wire logic [7:0] card_blk_q,
    input  wire logic [7:0] card_len_q,
    output var  logic       card_rvalid,
    output var  logic [7:0] card_rdata,
    output var  logic       card_done,
    output var  logic       card_err,
    output var  logic [7:0] card_stat
);
    initial begin
        {card_rvalid, card_done, card_err} = 3'h0;
        {card_rdata, card_stat} = 16'h0000;
        forever begin
            @(posedge clock);
            if (card_req_q === 1'b1) begin
                repeat (slow ? 6 : 1) @(posedge clock);
                // let written bytes pass first
                if (card_op_q inside {OP_WRITE, OP_INC, OP_DEC,
                                      OP_RESTORE, OP_NATIVE}) begin
                    repeat (card_len_q + 2) @(posedge clock);
                end
                for (int i = 0; i < card_len_q && card_op_q == OP_READ;
                     i++) begin
                    card_rvalid <= 1'b1;
                    card_rdata  <= card_blk_q + 8'(i);
                    @(posedge clock);
                end
                card_rvalid <= 1'b0;
                card_rdata  <= ~card_rdata;
                card_done   <= 1'b1;
                card_stat   <= (card_op_q == OP_NATIVE) ? 8'h5a : 8'h00;
                @(posedge clock);
                card_done   <= 1'b0;
            end
        end
    end
endmodule // ccai_card_model
`default_nettype wire

/* verification/ccai_top_tb.sv */
// self-checking bench of the command interpreter
// assumes the card model answers every card request
`timescale 1ns/1ps
`default_nettype none
module ccai_top_tb;
    import ccai_pkg::*;
    // name codes below are arbitrary values
    localparam logic [15:0] GA = 16'h5a01, GB = 16'h5a02;
    localparam logic [15:0] GV = 16'h5a03, GT = 16'h5a04;
    logic clock = 1'b0, rst = 1'b1, slow = 1'b0, opt_bp_off = 1'b0;
    logic card_arrive = 1'b0, card_bp_cap = 1'b0, cmd_valid = 1'b0;
    logic cmd_data_valid = 1'b0, done_seen, card_rvalid, card_done;
    logic card_err, cmd_ready_q, cmd_data_ready_q, rsp_valid_q;
    logic rsp_done_q, card_high_level_q, card_req_q, card_wvalid_q;
    logic [2:0]  card_family = 3'h0;
    logic [3:0]  card_op_q, op_log [0:3];
    logic [7:0]  opt_reg = 8'h00, cmd_data = 8'h00, cmd_p1, cmd_p2;
    logic [7:0]  cmd_cla = CLA_DIRECT, cmd_ins, cmd_len, rsp_data_q;
    logic [7:0]  card_blk_q, card_len_q, card_wdata_q, card_rdata;
    logic [7:0]  card_stat, rbuf [0:255], wbuf [0:255], lblk, llen;
    logic [15:0] rsp_sw_q, card_name_code_q;
    int nr, nw, nreq, n, miscompares = 0, comparisons = 0;
    initial {cmd_ins, cmd_p1, cmd_p2, cmd_len} = 32'h0;
    always #5 clock = ~clock;
    ccai_top #(.NAME_GEN_A(GA), .NAME_GEN_B(GB), .NAME_VICINITY(GV),
        .NAME_VIRTUAL(GT)) uut (.*);
    ccai_card_model u_card (.*);
    // capture
    always @(posedge clock) begin
        if (rsp_valid_q === 1'b1) rbuf[nr++] = rsp_data_q;
        if (card_wvalid_q === 1'b1) wbuf[nw++] = card_wdata_q;
        if (card_req_q === 1'b1) begin
            op_log[nreq[1:0]] = card_op_q;
            {lblk, llen} = {card_blk_q, card_len_q};
            nreq++;
        end
        if (rsp_done_q === 1'b1) done_seen = 1'b1;
    end
    task automatic chk(input logic [15:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one command, ends at a negedge
    task cmd(input logic [7:0] ins, p1, p2, len, input int nd);
        @(posedge clock);
        {nr, nw, nreq, done_seen} = 0;
        cmd_valid <= 1'b1;
        {cmd_ins, cmd_p1, cmd_p2, cmd_len} <= {ins, p1, p2, len};
        for (n = 0; n < 100 && cmd_ready_q !== 1'b1; n++)
            @(negedge clock);
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (int i = 0; i < nd; i++) begin
            cmd_data_valid <= 1'b1;
            cmd_data       <= 8'h30 + 8'(i);
            for (n = 0; n < 100 && cmd_data_ready_q !== 1'b1; n++)
                @(negedge clock);
            @(posedge clock);
        end
        cmd_data_valid <= 1'b0;
        for (n = 0; n < 3000 && done_seen !== 1'b1; n++)
            @(negedge clock);
        chk(16'(done_seen), 16'h1, "end");
    endtask
    task arrive(input logic [2:0] fam, input logic bp);
        @(posedge clock);
        {card_arrive, card_family, card_bp_cap} <= {1'b1, fam, bp};
        @(posedge clock);
        card_arrive <= 1'b0;
        @(negedge clock);
    endtask
    task t_reset();
        @(posedge clock);
        @(negedge clock);
        chk(rsp_sw_q, SW_OK, "rst sw");
        chk(16'(cmd_ready_q), 16'h1, "rst rdy");
    endtask
    task t_names();
        logic [15:0] e [0:6];
        logic [15:0] x;
        e = '{NAME_NONE, NAME_MEM1K, NAME_MEM4K, GA, GB, GV, GT};
        for (int h = 0; h < 2; h++) begin
            for (int f = 0; f < 7; f++) begin
                opt_reg <= {1'b0, h[0], 6'h00};
                arrive(3'(f), 1'b0);
                x = (h == 1 && f >= 3) ? NAME_NONE : e[f];
                chk(card_name_code_q, x, "name");
                cmd(INS_GET_NAME, 8'h00, 8'h00, 8'h02, 0);
                chk({rbuf[0], rbuf[1]}, x, "bytes");
            end
        end
    endtask
    task t_level();
        arrive(FAM_MEM1K, 1'b1);
        chk(16'(card_high_level_q), 16'h1, "lvl");
        cmd(INS_SLOT, 8'h20, 8'h00, 8'h00, 0);
        chk(16'(card_high_level_q), 16'h0, "desel");
        cmd(INS_SLOT, 8'h10, 8'h03, 8'h00, 0);
        arrive(FAM_MEM1K, 1'b1);
        chk(16'(card_high_level_q), 16'h0, "frst");
        arrive(FAM_MEM1K, 1'b1);
        chk(16'(card_high_level_q), 16'h1, "once");
        opt_bp_off <= 1'b1;
        arrive(FAM_MEM1K, 1'b1);
        chk(16'(card_high_level_q), 16'h0, "opt");
        opt_bp_off <= 1'b0;
    endtask
    task t_read();
        arrive(FAM_MEM1K, 1'b0);
        cmd(INS_READ, 8'h00, 8'h04, 8'h00, 0);
        chk(16'(llen), 16'd48, "llen");
        chk(16'(nr), 16'd48, "nr48");
        chk(16'(rbuf[47]), 16'd51, "last");
        slow <= 1'b1;
        cmd(INS_READ, 8'h00, 8'h05, 8'h00, 0);
        chk(16'(nr), 16'd16, "nr16");
        slow <= 1'b0;
        cmd(INS_READ, 8'h00, 8'h04, 8'h14, 0);
        chk(rsp_sw_q, SW_LEN, "len sw");
        chk(16'(nreq), 16'h0, "len req");
        cmd(INS_READ, 8'h00, 8'h06, 8'h30, 0);
        chk(rsp_sw_q, SW_P1P2, "cross sw");
        chk(16'(nreq), 16'h0, "cross req");
        arrive(FAM_MEM4K, 1'b0);
        cmd(INS_READ, 8'h00, 8'h80, 8'h00, 0);
        chk(16'(nr), 16'd240, "nr240");
    endtask
    task t_update();
        cmd(INS_UPDATE, 8'h00, 8'h04, 8'h10, 16);
        chk({4'h0, op_log[0], lblk}, 16'h0204, "wop");
        chk(16'(nw), 16'd16, "nw");
        chk({wbuf[0], wbuf[15]}, 16'h303f, "word");
        cmd(INS_UPDATE, 8'h00, 8'h00, 8'h10, 16);
        chk(16'(nreq), 16'h0, "blk0");
    endtask
    task t_value();
        for (int p = 0; p < 3; p++) begin
            cmd(INS_VALUE, 8'(p), 8'h05, VALUE_LEN, 4);
            chk(16'(op_log[0]), 16'(p + 3), "vop");
            chk(16'(op_log[1]), 16'(OP_TRANSFER), "xfer");
        end
    endtask
    task t_wrap();
        arrive(FAM_SECURE1, 1'b1);
        cmd(INS_WRAP, 8'h00, 8'h00, 8'h02, 2);
        chk(16'(op_log[0]), 16'(OP_NATIVE), "nop");
        chk(rsp_sw_q, {SW_NATIVE, 8'h5a}, "nsw");
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_names();
        t_level();
        t_read();
        t_update();
        t_value();
        t_wrap();
        close_out();
    end
    initial begin
        #1_000_000;
        miscompares++;
        close_out();
    end
endmodule // ccai_top_tb
`default_nettype wire
